/* File: hdl/ptp_tx_message_detect_config.v */
/*
 * Transmit timing-message detection: holds the detection configuration
 * register and classifies each outgoing frame from the transmit MAC
 * byte stream as a timing message or not.
 * Assumes the byte stream and the register port run on clk, frames are
 * untagged, IPv4 headers carry no options, and the custom MAC address
 * comes from registers held elsewhere on the same clock.
 */
`timescale 1ns/10ps
`include "ptp_tx_detect_consts.vh"

module ptp_tx_message_detect_config (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire [`REG_ADDR_W-1:0] reg_addr,
  input  wire [31:0]            reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [31:0]            reg_rdata,
  input  wire [47:0]            custom_mac,
  input  wire                   tx_valid,
  input  wire                   tx_sof,
  input  wire                   tx_eof,
  input  wire [7:0]             tx_data,
  output reg                    msg_hit,
  output reg                    msg_done,
  output reg  [1:0]             msg_kind
);

  reg [`CFG_W-1:0] cfg_q;
  reg [5:0]        pos_q;
  reg [47:0]       da_q;
  reg [15:0]       etype_q;
  reg [7:0]        proto_q;
  reg [31:0]       dip4_q;
  reg              v6_pre_q;
  reg              v6_link_q;
  reg [15:0]       tail6_q;
  reg [15:0]       port_q;
  reg [15:0]       hit_cnt_q;
  reg [15:0]       frm_cnt_q;

  wire [5:0] pos_cur = tx_sof ? 6'h00 : pos_q;
  wire [4:0] grp_en  = cfg_q[`CFG_GRP_HI:`CFG_GRP_LO];

  // Bit 4 of en is group one, bit 0 group five
  function grp_tail_hit;
    input [15:0] tail;
    input [4:0]  en;
    begin
      grp_tail_hit = (en[4] && tail == `TAIL_GRP1) ||
                     (en[3] && tail == `TAIL_GRP2) ||
                     (en[2] && tail == `TAIL_GRP3) ||
                     (en[1] && tail == `TAIL_GRP4) ||
                     (en[0] && tail == `TAIL_GRP5);
    end
  endfunction

  // UDP destination port of an event or general message
  function ptp_udp_hit;
    input [7:0]  proto;
    input [15:0] port;
    begin
      ptp_udp_hit = proto == `IP_PROTO_UDP &&
                    (port == `UDP_EVENT_PORT || port == `UDP_GENERAL_PORT);
    end
  endfunction

  // Group multicast MAC: fixed prefix and an enabled group tail
  function grp_mac_hit;
    input [47:0] da;
    input [31:0] prefix;
    input [4:0]  en;
    begin
      grp_mac_hit = da[47:16] == prefix && grp_tail_hit(da[15:0], en);
    end
  endfunction

  // Byte position in the frame, held at its ceiling past the header
  always @(posedge clk) begin
    if (!rst_n) begin
      pos_q <= 6'h00;
    end else if (tx_valid && pos_cur != `POS_MAX) begin
      pos_q <= pos_cur + 6'h01;
    end
  end

  // Destination MAC, shifted in over the first six bytes
  always @(posedge clk) begin
    if (!rst_n) begin
      da_q <= 48'h000000000000;
    end else if (tx_valid && pos_cur < 6'h06) begin
      da_q <= {da_q[39:0], tx_data};
    end
  end

  // Ethertype of an untagged frame
  always @(posedge clk) begin
    if (!rst_n) begin
      etype_q <= 16'h0000;
    end else if (tx_valid && (pos_cur == `POS_ETYPE_LO - 6'h01 ||
                              pos_cur == `POS_ETYPE_LO)) begin
      etype_q <= {etype_q[7:0], tx_data};
    end
  end

  // IPv4 protocol or IPv6 next header
  always @(posedge clk) begin
    if (!rst_n) begin
      proto_q <= 8'h00;
    end else if (tx_valid) begin
      if (pos_cur == `POS_V4_PROTO && etype_q == `ETH_V4) begin
        proto_q <= tx_data;
      end
      if (pos_cur == `POS_V6_NEXT && etype_q == `ETH_V6) begin
        proto_q <= tx_data;
      end
    end
  end

  // IPv4 destination address
  always @(posedge clk) begin
    if (!rst_n) begin
      dip4_q <= 32'h00000000;
    end else if (tx_valid && etype_q == `ETH_V4 &&
                 pos_cur >= `POS_V4_DIP_LO && pos_cur <= `POS_V4_DIP_HI) begin
      dip4_q <= {dip4_q[23:0], tx_data};
    end
  end

  // IPv6 destination shape: FF, a scope byte with zero upper nibble and
  // twelve zero bytes; any byte that breaks it clears the flag
  always @(posedge clk) begin
    if (!rst_n) begin
      v6_pre_q <= 1'b0;
    end else if (tx_valid) begin
      if (tx_sof) begin
        v6_pre_q <= 1'b1;
      end
      if (etype_q == `ETH_V6) begin
        if (pos_cur == `POS_V6_DIP_FIRST && tx_data != `IP6_FIRST) begin
          v6_pre_q <= 1'b0;
        end
        if (pos_cur == `POS_V6_DIP_SCOPE && tx_data[7:4] != 4'h0) begin
          v6_pre_q <= 1'b0;
        end
        if (pos_cur >= `POS_V6_ZERO_LO && pos_cur <= `POS_V6_ZERO_HI &&
            tx_data != 8'h00) begin
          v6_pre_q <= 1'b0;
        end
      end
    end
  end

  // IPv6 link-local scope, needed by group five only
  always @(posedge clk) begin
    if (!rst_n) begin
      v6_link_q <= 1'b0;
    end else if (tx_valid && etype_q == `ETH_V6 &&
                 pos_cur == `POS_V6_DIP_SCOPE) begin
      v6_link_q <= tx_data == `IP6_LINK_SCOPE;
    end
  end

  // Last two bytes of the IPv6 destination address
  always @(posedge clk) begin
    if (!rst_n) begin
      tail6_q <= 16'h0000;
    end else if (tx_valid && etype_q == `ETH_V6 &&
                 (pos_cur == `POS_V6_DIP_HI - 6'h01 ||
                  pos_cur == `POS_V6_DIP_HI)) begin
      tail6_q <= {tail6_q[7:0], tx_data};
    end
  end

  // UDP destination port of either IP kind
  always @(posedge clk) begin
    if (!rst_n) begin
      port_q <= 16'h0000;
    end else if (tx_valid &&
                 ((etype_q == `ETH_V4 && (pos_cur == `POS_V4_PORT_LO ||
                   pos_cur == `POS_V4_PORT_HI)) ||
                  (etype_q == `ETH_V6 && (pos_cur == `POS_V6_PORT_LO ||
                   pos_cur == `POS_V6_PORT_HI)))) begin
      port_q <= {port_q[7:0], tx_data};
    end
  end

  // Classification of the captured frame
  reg       is_l2;
  reg       is_v4;
  reg       is_v6;
  reg       mac_ok;
  reg       ip_ok;
  reg       hit_d;
  reg [1:0] kind_d;
  always @* begin
    is_l2 = etype_q == `ETH_L2;
    is_v4 = etype_q == `ETH_V4 && ptp_udp_hit(proto_q, port_q);
    is_v6 = etype_q == `ETH_V6 && ptp_udp_hit(proto_q, port_q);
    mac_ok = 1'b0;
    ip_ok  = 1'b1;
    kind_d = `KIND_NONE;
    if (is_l2) begin
      kind_d = `KIND_L2;
      mac_ok = (cfg_q[`CFG_L2_FIX_A] && da_q == `MAC_L2_FIX_A) ||
               (cfg_q[`CFG_L2_FIX_B] && da_q == `MAC_L2_FIX_B) ||
               (cfg_q[`CFG_L2_USER] && da_q == custom_mac);
    end else if (is_v4) begin
      kind_d = `KIND_V4;
      mac_ok = grp_mac_hit(da_q, `MAC_V4_PREFIX, grp_en) ||
               (cfg_q[`CFG_V4_USER] && da_q == custom_mac);
      ip_ok  = dip4_q[31:16] == `IP4_PREFIX &&
               grp_tail_hit(dip4_q[15:0], grp_en);
    end else if (is_v6) begin
      kind_d = `KIND_V6;
      mac_ok = grp_mac_hit(da_q, `MAC_V6_PREFIX, grp_en) ||
               (cfg_q[`CFG_V6_USER] && da_q == custom_mac);
      // Group five is link-local scope only
      ip_ok  = v6_pre_q &&
               grp_tail_hit(tail6_q, grp_en & {4'hF, v6_link_q});
    end
    if (!cfg_q[`CFG_MAC_CHK]) begin
      mac_ok = 1'b1;
    end
    if (!cfg_q[`CFG_IP_CHK]) begin
      ip_ok = 1'b1;
    end
    hit_d = ((is_l2 && cfg_q[`CFG_L2_DET]) ||
             (is_v6 && cfg_q[`CFG_V6_DET]) ||
             (is_v4 && cfg_q[`CFG_V4_DET])) &&
            mac_ok && ip_ok;
  end

  // Decision is taken on the cycle after the last byte, so the last
  // byte's capture is already visible to the classifier
  reg eof_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      eof_q    <= 1'b0;
      msg_hit  <= 1'b0;
      msg_done <= 1'b0;
      msg_kind <= `KIND_NONE;
    end else begin
      eof_q    <= tx_valid && tx_eof;
      msg_done <= eof_q;
      msg_hit  <= eof_q && hit_d;
      if (eof_q) begin
        msg_kind <= hit_d ? kind_d : `KIND_NONE;
      end
    end
  end

  // Classified and hit frame counts for the status word; both wrap
  always @(posedge clk) begin
    if (!rst_n) begin
      hit_cnt_q <= 16'h0000;
      frm_cnt_q <= 16'h0000;
    end else if (eof_q) begin
      frm_cnt_q <= frm_cnt_q + 16'h0001;
      if (hit_d) begin
        hit_cnt_q <= hit_cnt_q + 16'h0001;
      end
    end
  end

  // Register port; configuration stability while the timestamp unit
  // runs is left to software
  always @(posedge clk) begin
    if (!rst_n) begin
      cfg_q <= `CFG_RESET;
    end else if (reg_wr && reg_addr == `REG_CFG_OFS) begin
      cfg_q <= reg_wdata[`CFG_W-1:0];
    end
  end

  // Read data stands for one cycle after the strobe, zero otherwise
  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd && reg_addr == `REG_CFG_OFS) begin
      reg_rdata <= {17'h00000, cfg_q};
    end else if (reg_rd && reg_addr == `REG_STAT_OFS) begin
      reg_rdata <= {hit_cnt_q, frm_cnt_q};
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // ptp_tx_message_detect_config

/* File: shared/ptp_tx_detect_consts.vh */
/*
 * Constants for the transmit timing-message detection block: register
 * offsets, field positions, reset values and the fixed frame patterns.
 * Assumes byte addressing on the register port and untagged frames.
 */
`ifndef PTP_TX_DETECT_CONSTS_VH
`define PTP_TX_DETECT_CONSTS_VH

`define REG_ADDR_W          12
`define REG_CFG_OFS         12'h158
`define REG_STAT_OFS        12'h1F0
`define CFG_RESET           15'h711F
`define CFG_W               15

`define CFG_V4_DET          0
`define CFG_V6_DET          1
`define CFG_L2_DET          2
`define CFG_MAC_CHK         3
`define CFG_IP_CHK          4
`define CFG_V4_USER         5
`define CFG_V6_USER         6
`define CFG_L2_USER         7
`define CFG_GRP_LO          8
`define CFG_GRP_HI          12
`define CFG_L2_FIX_B        13
`define CFG_L2_FIX_A        14

`define KIND_NONE           2'h0
`define KIND_V4             2'h1
`define KIND_V6             2'h2
`define KIND_L2             2'h3

`define MAC_L2_FIX_A        48'h0180C200000E
`define MAC_L2_FIX_B        48'h011B19000000
`define MAC_V4_PREFIX       32'h01005E00
`define MAC_V6_PREFIX       32'h33330000
`define IP4_PREFIX          16'hE000
`define IP6_FIRST           8'hFF
`define IP6_LINK_SCOPE      8'h02
`define TAIL_GRP1           16'h0181
`define TAIL_GRP2           16'h0182
`define TAIL_GRP3           16'h0183
`define TAIL_GRP4           16'h0184
`define TAIL_GRP5           16'h006B

`define ETH_L2              16'h88F7
`define ETH_V4              16'h0800
`define ETH_V6              16'h86DD
`define IP_PROTO_UDP        8'h11
`define UDP_EVENT_PORT      16'h013F
`define UDP_GENERAL_PORT    16'h0140

`define POS_ETYPE_LO        6'h0D
`define POS_V4_PROTO        6'h17
`define POS_V4_DIP_LO       6'h1E
`define POS_V4_DIP_HI       6'h21
`define POS_V4_PORT_LO      6'h24
`define POS_V4_PORT_HI      6'h25
`define POS_V6_NEXT         6'h14
`define POS_V6_DIP_FIRST    6'h26
`define POS_V6_DIP_SCOPE    6'h27
`define POS_V6_ZERO_LO      6'h28
`define POS_V6_ZERO_HI      6'h33
`define POS_V6_DIP_HI       6'h35
`define POS_V6_PORT_LO      6'h38
`define POS_V6_PORT_HI      6'h39
`define POS_MAX             6'h3F

`endif

/* File: testbench/ptp_tx_detect_asserts.sv */
/* Port checker for the transmit detection block.
   Assumes the shared constants header and one clock with sync reset. */
`timescale 1ns/10ps
`include "ptp_tx_detect_consts.vh"
module ptp_tx_detect_asserts (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic [`REG_ADDR_W-1:0] reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata,
  input wire logic                   tx_valid,
  input wire logic                   tx_eof,
  input wire logic                   msg_hit,
  input wire logic                   msg_done,
  input wire logic [1:0]             msg_kind
);
  logic [14:0] cfg_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shadow of the configuration as software wrote it
  always @(posedge clk) begin
    if (!rst_n) cfg_q <= `CFG_RESET;
    else if (reg_wr && reg_addr == `REG_CFG_OFS) cfg_q <= reg_wdata[14:0];
  end
  hit_needs_done_a: assert property (msg_hit |-> msg_done)
    else $error("hit pulse without done pulse");
  eof_gives_done_a: assert property (tx_valid && tx_eof |-> ##2 msg_done)
    else $error("no done two cycles after last byte");
  done_from_eof_a: assert property (msg_done |->
    $past(tx_eof, 2) && $past(tx_valid, 2))
    else $error("done pulse without a last byte before it");
  miss_kind_a: assert property (msg_done && !msg_hit |->
    msg_kind == `KIND_NONE)
    else $error("kind set on a missed frame");
  kind_holds_a: assert property (!msg_done |-> $stable(msg_kind))
    else $error("kind changed without done");
  l2_gate_a: assert property (msg_hit && msg_kind == `KIND_L2 |->
    cfg_q[`CFG_L2_DET])
    else $error("layer 2 hit while layer 2 detect off");
  v6_gate_a: assert property (msg_hit && msg_kind == `KIND_V6 |->
    cfg_q[`CFG_V6_DET])
    else $error("IPv6 hit while IPv6 detect off");
  v4_gate_a: assert property (msg_hit && msg_kind == `KIND_V4 |->
    cfg_q[`CFG_V4_DET])
    else $error("IPv4 hit while IPv4 detect off");
  cfg_readback_a: assert property ($past(reg_rd) &&
    $past(reg_addr) == `REG_CFG_OFS |-> reg_rdata == {17'h0, cfg_q})
    else $error("configuration read back wrong");
endmodule // ptp_tx_detect_asserts

bind ptp_tx_message_detect_config ptp_tx_detect_asserts ptp_tx_detect_asserts_i (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_valid(tx_valid), .tx_eof(tx_eof), .msg_hit(msg_hit),
  .msg_done(msg_done), .msg_kind(msg_kind));

/* File: testbench/tx_mac_source.sv */
/* Transmit MAC model: sends one 58-byte frame per go pulse.
   Assumes go is pulsed only while no frame is in flight. */
`timescale 1ns/10ps
module tx_mac_source (
  input  wire logic         clk,
  input  wire logic         go,
  input  wire logic [463:0] frame,
  output logic              tx_valid,
  output logic              tx_sof,
  output logic              tx_eof,
  output logic [7:0]        tx_data
);
  logic [6:0] idx_q = 7'h00;
  initial {tx_valid, tx_sof, tx_eof, tx_data} = 11'h000;
  always @(posedge clk) begin
    if (go || (idx_q != 7'h00 && idx_q < 7'h3A)) begin
      tx_valid <= 1'b1;
      tx_sof   <= idx_q == 7'h00;
      tx_eof   <= idx_q == 7'h39;
      tx_data  <= frame[463 - 8 * idx_q -: 8];
      idx_q    <= idx_q + 7'h01;
    end else begin
      // Idle bytes keep changing so a stale byte is never mistaken
      {tx_valid, tx_sof, tx_eof} <= 3'h0;
      tx_data <= ~tx_data;
      idx_q   <= 7'h00;
    end
  end
endmodule // tx_mac_source

/* File: testbench/ptp_tx_message_detect_config_test.sv */
/* Self-checking bench for the transmit detection block.
   Assumes the shared constants header and the MAC source model. */
`timescale 1ns/10ps
`include "ptp_tx_detect_consts.vh"
module ptp_tx_message_detect_config_test;
  typedef struct {logic [14:0] cfg; logic [1:0] kind; logic [47:0] da;
    logic [15:0] tail; logic hit;} row_t;
  localparam logic [1:0] L2 = `KIND_L2, V4 = `KIND_V4, V6 = `KIND_V6;
  localparam logic [47:0] A = `MAC_L2_FIX_A, B = `MAC_L2_FIX_B;
  localparam logic [47:0] C = 48'h02AABBCCDDEE, M = 48'h01005E000181;
  logic         clk, rst_n, reg_wr, reg_rd, go, msg_hit, msg_done;
  logic         tx_valid, tx_sof, tx_eof;
  logic [11:0]  reg_addr;
  logic [31:0]  reg_wdata, reg_rdata, rd;
  logic [7:0]   tx_data;
  logic [1:0]   msg_kind;
  logic [463:0] frame;
  int           n_errors = 0, samples_checked = 0, hits = 0, i, k;
  row_t rows[19] = '{
    '{15'h711F, L2, A, 0, 1}, '{15'h311F, L2, A, 0, 0},
    '{15'h711F, L2, B, 0, 1}, '{15'h511F, L2, B, 0, 0},
    '{15'h711F, V4, 0, 16'h0181, 1}, '{15'h711F, V6, 0, 16'h0181, 1},
    '{15'h081F, V4, 0, 16'h0182, 1}, '{15'h011F, V4, 0, 16'h0182, 0},
    '{15'h041F, V6, 0, 16'h0183, 1}, '{15'h021F, V4, 0, 16'h0184, 1},
    '{15'h011F, V6, 0, 16'h006B, 1}, '{15'h009F, L2, C, 0, 1},
    '{15'h104F, V6, C, 16'h0181, 1}, '{15'h102F, V4, C, 16'h0181, 1},
    '{15'h100F, V4, M, 16'h0199, 1}, '{15'h101F, V4, M, 16'h0199, 0},
    '{15'h1017, V4, C, 16'h0181, 1}, '{15'h711D, V6, 0, 16'h0181, 0},
    '{15'h711E, V4, 0, 16'h0181, 0}};

  ptp_tx_message_detect_config ptp_tx_message_detect_config_i (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .custom_mac(C), .tx_valid(tx_valid), .tx_sof(tx_sof), .tx_eof(tx_eof),
    .tx_data(tx_data), .msg_hit(msg_hit), .msg_done(msg_done),
    .msg_kind(msg_kind));
  tx_mac_source tx_mac_source_i (.clk(clk), .go(go), .frame(frame),
    .tx_valid(tx_valid), .tx_sof(tx_sof), .tx_eof(tx_eof), .tx_data(tx_data));

  function automatic logic [463:0] mk(row_t r);
    logic [463:0] f;
    f = '0;
    f[463:416] = r.da != 0 ? r.da :
      {r.kind == V4 ? `MAC_V4_PREFIX : `MAC_V6_PREFIX, r.tail};
    case (r.kind)
      L2: f[367:352] = `ETH_L2;
      V4: begin
        f[367:344] = {`ETH_V4, 8'h45};
        f[279:272] = `IP_PROTO_UDP;
        f[223:192] = {`IP4_PREFIX, r.tail};
        f[175:160] = `UDP_EVENT_PORT;
      end
      default: begin
        f[367:344] = {`ETH_V6, 8'h60};
        f[303:296] = `IP_PROTO_UDP;
        f[159:144] = {`IP6_FIRST, `IP6_LINK_SCOPE};
        f[47:32]   = r.tail;
        f[15:0]    = `UDP_EVENT_PORT;
      end
    endcase
    return f;
  endfunction

  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rd_reg(input logic [11:0] a);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rd = reg_rdata;
  endtask

  task stop_test;
    $display("errors %0d of %0d checks", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #(50 * 6000);
    n_errors++;
    stop_test;
  end

  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, go, frame} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`REG_CFG_OFS);
    check("cfg reset", 32'h711F, rd);
    for (i = 0; i < 19; i++) begin
      wr_reg(`REG_CFG_OFS, {17'h0, rows[i].cfg});
      frame <= mk(rows[i]);
      go    <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (k = 0; k < 100 && msg_done !== 1'b1; k++) @(negedge clk);
      hits += rows[i].hit;
      check("done", 1, {31'h0, msg_done});
      check("hit", {31'h0, rows[i].hit}, {31'h0, msg_hit});
      check("kind", rows[i].hit ? rows[i].kind : 0, {30'h0, msg_kind});
    end
    rd_reg(`REG_STAT_OFS);
    check("status", {16'(hits), 16'd19}, rd);
    wr_reg(`REG_CFG_OFS, 32'hFFFFFFFF);
    rd_reg(`REG_CFG_OFS);
    check("cfg reserved", 32'h7FFF, rd);
    rd_reg(12'h004);
    check("unmapped", 32'h0, rd);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`REG_CFG_OFS);
    check("cfg rereset", 32'h711F, rd);
    stop_test;
  end
endmodule // ptp_tx_message_detect_config_test
